// *** logic/tle_params.svh ***
`ifndef TLE_PARAMS_SVH
`define TLE_PARAMS_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TLE_OFS_CLK_CTRL 8'h00
`define TLE_OFS_LINK_HEALTH 8'h08
`define TLE_OFS_BLK_LEVEL 8'h0C
`define TLE_OFS_EB_STATE 8'h14
`define TLE_OFS_DATA_POP 8'h18
`define TLE_OFS_LINK_CTRL 8'h1C
`define TLE_OFS_LEN_POP 8'h20
// ----------------------------------------
// reset values
// ----------------------------------------
`define TLE_CLK_CTRL_RST 3'h7
`define TLE_LINK_CTRL_RST 3'h3
// ----------------------------------------
// field positions
// ----------------------------------------
`define TLE_BIT_GLOBAL_REFCLK 0
`define TLE_BIT_ETH_REFCLK 1
`define TLE_BIT_IDELAY_REF 2
`define TLE_BIT_LINK_RX_RST 0
`define TLE_BIT_CMD_FIFO_RST 1
`define TLE_BIT_EB_RST 2
`define TLE_BIT_LOCKED 17
`define TLE_BIT_LINK_UP 16
`define TLE_BIT_SYNC 31
`define TLE_BIT_END 16
`define TLE_BIT_LEN_EMPTY 3
`define TLE_BIT_DATA_EMPTY 0
// ----------------------------------------
// buffer sizes and error counter limit
// ----------------------------------------
`define TLE_DATA_DEPTH 16
`define TLE_DATA_AW 4
`define TLE_LEN_DEPTH 4
`define TLE_LEN_AW 2
`define TLE_ERR_MAX 16'hFFFF
`endif

// *** logic/tle_pkg.sv ***
`default_nettype none
`include "tle_params.svh"
package tle_pkg;
    typedef logic [31:0] tle_word_t;
    typedef logic [7:0] tle_level_t;
    typedef logic [15:0] tle_err_t;
    typedef logic [7:0] tle_addr_t;
    // data buffer entry: sync, end marker, word
    typedef struct packed {
        logic sync;
        logic last;
        tle_word_t word;
    } tle_data_entry_s;
    typedef struct packed {
        logic [2:0] clk_ctrl;
        logic [2:0] link_ctrl;
        logic locked;
        logic link_up;
        tle_level_t next_lvl;
        tle_level_t cur_lvl;
        tle_word_t prdata;
        logic pready;
        logic pslverr;
    } tle_top_s;
endpackage : tle_pkg
`default_nettype wire

// *** logic/tle_fifo.sv ***
`timescale 1ns/10ps
`default_nettype none
module tle_fifo #(
    parameter int W = 32,
    parameter int DEPTH = 4,
    parameter int AW = 2
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic flush,
    input wire logic in_valid,
    input wire logic [W-1:0] in_data,
    output logic in_ready,
    input wire logic out_pop,
    output logic [W-1:0] out_data,
    output logic out_empty,
    output logic [AW:0] count
);
    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0] cnt;
        logic ready;
        logic empty;
    } tle_fifo_st_s;
    localparam tle_fifo_st_s RST = '{mem: '0, wr: '0, rd: '0, cnt: '0, ready: 1'b1, empty: 1'b1};
    localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
    tle_fifo_st_s st_reg;
    tle_fifo_st_s st_next;
    logic push;
    logic pop;
    assign push = in_valid && st_reg.ready;
    assign pop = out_pop && !st_reg.empty;
    always_comb begin
        st_next = st_reg;
        if (push) begin
            st_next.mem[st_reg.wr] = in_data;
            st_next.wr = st_reg.wr + 1'b1;
        end
        if (pop) begin
            st_next.rd = st_reg.rd + 1'b1;
        end
        case ({push, pop})
            2'b10: st_next.cnt = st_reg.cnt + 1'b1;
            2'b01: st_next.cnt = st_reg.cnt - 1'b1;
            default: st_next.cnt = st_reg.cnt;
        endcase
        st_next.ready = (st_next.cnt != FULL_CNT);
        st_next.empty = (st_next.cnt == '0);
        if (flush) begin
            st_next.wr = '0;
            st_next.rd = '0;
            st_next.cnt = '0;
            st_next.ready = 1'b1;
            st_next.empty = 1'b1;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= RST;
        end else begin
            st_reg <= st_next;
        end
    end
    assign in_ready = st_reg.ready;
    assign out_data = st_reg.mem[st_reg.rd];
    assign out_empty = st_reg.empty;
    assign count = st_reg.cnt;

    chk_pop_once: assert property (@(posedge pclk) disable iff (!presetn)
        (pop && !push && !flush) |=> (st_reg.cnt == $past(st_reg.cnt) - 1'b1))
        else $error("pop did not remove exactly one entry");
    chk_empty_track: assert property (@(posedge pclk) disable iff (!presetn)
        st_reg.empty == (st_reg.cnt == '0))
        else $error("empty flag disagrees with count");
endmodule : tle_fifo
`default_nettype wire

// *** logic/tle_err_counter.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tle_params.svh"
module tle_err_counter (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clear,
    input wire logic code_err,
    input wire logic disp_err,
    output tle_pkg::tle_err_t count
);
    import tle_pkg::*;
    typedef struct packed {
        tle_err_t cnt;
    } tle_err_st_s;
    tle_err_st_s st_reg;
    tle_err_st_s st_next;
    logic [16:0] sum;
    always_comb begin
        st_next = st_reg;
        sum = {1'b0, st_reg.cnt} + {15'h0000, code_err} + {15'h0000, disp_err};
        // saturate instead of wrapping
        st_next.cnt = sum[16] ? `TLE_ERR_MAX : sum[15:0];
        if (clear) begin
            st_next.cnt = '0;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end
    assign count = st_reg.cnt;

    chk_err_saturate: assert property (@(posedge pclk) disable iff (!presetn)
        (st_reg.cnt == `TLE_ERR_MAX && !clear) |=> (st_reg.cnt == `TLE_ERR_MAX))
        else $error("error counter wrapped");
    chk_err_clear: assert property (@(posedge pclk) disable iff (!presetn)
        clear |=> (st_reg.cnt == '0))
        else $error("error counter not cleared by link reset");
    chk_err_count: assert property (@(posedge pclk) disable iff (!presetn)
        (!clear && code_err && disp_err && st_reg.cnt < 16'hFFFE)
        |=> (st_reg.cnt == $past(st_reg.cnt) + 16'h0002))
        else $error("simultaneous errors not both counted");
endmodule : tle_err_counter
`default_nettype wire

// *** logic/tle_link_eb_status.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tle_params.svh"
module tle_link_eb_status (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire tle_pkg::tle_addr_t paddr,
    input wire tle_pkg::tle_word_t pwdata,
    output tle_pkg::tle_word_t prdata,
    output logic pready,
    output logic pslverr,
    input wire logic link_locked_in,
    input wire logic link_up_in,
    input wire logic code_error_in,
    input wire logic disparity_error_in,
    input wire logic upcoming_level_valid,
    input wire tle_pkg::tle_level_t upcoming_block_level,
    input wire logic present_level_valid,
    input wire tle_pkg::tle_level_t present_block_level,
    input wire logic data_in_valid,
    input wire tle_pkg::tle_word_t data_in_word,
    input wire logic data_in_end,
    input wire logic data_in_sync,
    output logic data_in_ready,
    input wire logic length_in_valid,
    input wire tle_pkg::tle_word_t length_in_word,
    output logic length_in_ready,
    output logic global_refclk_reset,
    output logic ethernet_refclk_reset,
    output logic input_delay_ref_reset,
    output logic link_rx_reset,
    output logic command_fifo_reset,
    output logic event_buffer_reset
);
    import tle_pkg::*;
    // ----------------------------------------
    // state
    // ----------------------------------------
    localparam tle_top_s RST = '{clk_ctrl: `TLE_CLK_CTRL_RST, link_ctrl: `TLE_LINK_CTRL_RST,
        locked: 1'b0, link_up: 1'b0, next_lvl: 8'h00, cur_lvl: 8'h00, prdata: 32'h00000000,
        pready: 1'b0, pslverr: 1'b0};
    tle_top_s st_reg;
    tle_top_s st_next;
    logic setup;
    logic access;
    logic wr_access;
    logic data_pop;
    logic len_pop;
    logic unmapped;
    tle_word_t rdata;
    tle_data_entry_s data_head;
    tle_data_entry_s data_entry_in;
    tle_word_t len_head;
    logic data_empty;
    logic len_empty;
    logic [`TLE_DATA_AW:0] data_cnt;
    logic [`TLE_LEN_AW:0] len_cnt;
    tle_err_t err_cnt;
    logic data_rdy;
    logic len_rdy;
    logic head_sync;
    logic head_end;
    // ----------------------------------------
    // buffers and error counter
    // ----------------------------------------
    assign data_entry_in = '{sync: data_in_sync, last: data_in_end, word: data_in_word};
    tle_fifo #(.W(34), .DEPTH(`TLE_DATA_DEPTH), .AW(`TLE_DATA_AW)) u_data_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(st_reg.link_ctrl[`TLE_BIT_EB_RST]),
        .in_valid(data_in_valid),
        .in_data(data_entry_in),
        .in_ready(data_rdy),
        .out_pop(data_pop),
        .out_data(data_head),
        .out_empty(data_empty),
        .count(data_cnt)
    );
    tle_fifo #(.W(32), .DEPTH(`TLE_LEN_DEPTH), .AW(`TLE_LEN_AW)) u_len_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .flush(st_reg.link_ctrl[`TLE_BIT_EB_RST]),
        .in_valid(length_in_valid),
        .in_data(length_in_word),
        .in_ready(len_rdy),
        .out_pop(len_pop),
        .out_data(len_head),
        .out_empty(len_empty),
        .count(len_cnt)
    );
    tle_err_counter u_err (
        .pclk(pclk),
        .presetn(presetn),
        .clear(st_reg.link_ctrl[`TLE_BIT_LINK_RX_RST]),
        .code_err(code_error_in),
        .disp_err(disparity_error_in),
        .count(err_cnt)
    );
    // ----------------------------------------
    // apb decode
    // ----------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable && st_reg.pready;
    assign wr_access = access && pwrite;
    assign head_sync = data_head.sync && !data_empty;
    assign head_end = data_head.last && !data_empty;
    // popped with the setup capture, so a word pushed meanwhile is never lost
    assign data_pop = setup && !pwrite && (paddr == `TLE_OFS_DATA_POP);
    assign len_pop = setup && !pwrite && (paddr == `TLE_OFS_LEN_POP);
    always_comb begin
        rdata = 32'h00000000;
        unmapped = 1'b0;
        case (paddr)
            `TLE_OFS_CLK_CTRL: rdata = {29'h00000000, st_reg.clk_ctrl};
            `TLE_OFS_LINK_CTRL: rdata = {29'h00000000, st_reg.link_ctrl};
            `TLE_OFS_LINK_HEALTH: begin
                rdata = {14'h0000, st_reg.locked, st_reg.link_up, err_cnt};
            end
            `TLE_OFS_BLK_LEVEL: rdata = {16'h0000, st_reg.next_lvl, st_reg.cur_lvl};
            `TLE_OFS_EB_STATE: begin
                rdata = {head_sync, 8'h00, data_cnt, 1'b0, head_end,
                    7'h00, len_cnt, 2'h0, len_empty, 2'h0, data_empty};
            end
            // an empty buffer reads as zero and is not popped
            `TLE_OFS_DATA_POP: rdata = data_empty ? 32'h00000000 : data_head.word;
            `TLE_OFS_LEN_POP: rdata = len_empty ? 32'h00000000 : len_head;
            default: unmapped = 1'b1;
        endcase
    end
    // ----------------------------------------
    // next state
    // ----------------------------------------
    always_comb begin
        st_next = st_reg;
        st_next.locked = link_locked_in;
        st_next.link_up = link_up_in;
        if (upcoming_level_valid) begin
            st_next.next_lvl = upcoming_block_level;
        end
        if (present_level_valid) begin
            st_next.cur_lvl = present_block_level;
        end
        // read data is latched in setup, so access always completes at once
        st_next.pready = setup;
        st_next.pslverr = setup && unmapped;
        if (setup && !pwrite) begin
            st_next.prdata = rdata;
        end
        if (wr_access && paddr == `TLE_OFS_CLK_CTRL) begin
            st_next.clk_ctrl = pwdata[2:0];
        end
        if (wr_access && paddr == `TLE_OFS_LINK_CTRL) begin
            st_next.link_ctrl = pwdata[2:0];
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg <= RST;
        end else begin
            st_reg <= st_next;
        end
    end
    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign data_in_ready = data_rdy;
    assign length_in_ready = len_rdy;
    assign global_refclk_reset = st_reg.clk_ctrl[`TLE_BIT_GLOBAL_REFCLK];
    assign ethernet_refclk_reset = st_reg.clk_ctrl[`TLE_BIT_ETH_REFCLK];
    assign input_delay_ref_reset = st_reg.clk_ctrl[`TLE_BIT_IDELAY_REF];
    assign link_rx_reset = st_reg.link_ctrl[`TLE_BIT_LINK_RX_RST];
    assign command_fifo_reset = st_reg.link_ctrl[`TLE_BIT_CMD_FIFO_RST];
    assign event_buffer_reset = st_reg.link_ctrl[`TLE_BIT_EB_RST];
    // ----------------------------------------
    // checks
    // ----------------------------------------
    chk_locked_bit: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `TLE_OFS_LINK_HEALTH)
        |=> (prdata[`TLE_BIT_LOCKED] == $past(st_reg.locked)))
        else $error("locked bit wrong in health word");
    chk_link_up_bit: assert property (@(posedge pclk) disable iff (!presetn)
        $past(link_up_in) == st_reg.link_up || !$past(presetn))
        else $error("link up status not tracking input");
    chk_err_field: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `TLE_OFS_LINK_HEALTH)
        |=> (prdata[15:0] == $past(err_cnt) && prdata[`TLE_BIT_LINK_UP] == $past(st_reg.link_up)))
        else $error("error count field wrong in health word");
    chk_level_capture: assert property (@(posedge pclk) disable iff (!presetn)
        upcoming_level_valid |=> (st_reg.next_lvl == $past(upcoming_block_level)))
        else $error("next block level not captured");
    chk_cur_level: assert property (@(posedge pclk) disable iff (!presetn)
        present_level_valid |=> (st_reg.cur_lvl == $past(present_block_level)))
        else $error("current block level not captured");
    chk_eb_flags: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `TLE_OFS_EB_STATE)
        |=> (prdata[`TLE_BIT_LEN_EMPTY] == $past(len_empty)
            && prdata[`TLE_BIT_DATA_EMPTY] == $past(data_empty)
            && prdata[`TLE_BIT_SYNC] == $past(head_sync)
            && prdata[`TLE_BIT_END] == $past(head_end)))
        else $error("buffer state flags wrong");
    chk_data_pop_value: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && paddr == `TLE_OFS_DATA_POP && !data_empty)
        |=> (prdata == $past(data_head.word)) && pready)
        else $error("data readout word wrong");
    chk_refclk_write: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_access && paddr == `TLE_OFS_CLK_CTRL)
        |=> (global_refclk_reset == $past(pwdata[0]) && input_delay_ref_reset == $past(pwdata[2])))
        else $error("clock control write not applied");
    chk_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
        (setup && paddr == 8'h04) |=> (pready && pslverr))
        else $error("unmapped address not flagged");
endmodule : tle_link_eb_status
`default_nettype wire

// *** tb/tle_tip_model.sv ***
`timescale 1ns/10ps
`default_nettype none
module tle_tip_model (
    input wire logic pclk,
    output var logic link_locked_in,
    output var logic link_up_in,
    output var logic code_error_in,
    output var logic disparity_error_in,
    output var logic upcoming_level_valid,
    output var tle_pkg::tle_level_t upcoming_block_level,
    output var logic present_level_valid,
    output var tle_pkg::tle_level_t present_block_level,
    output var logic data_in_valid,
    output var tle_pkg::tle_word_t data_in_word,
    output var logic data_in_end,
    output var logic data_in_sync,
    input wire logic data_in_ready,
    output var logic length_in_valid,
    output var tle_pkg::tle_word_t length_in_word,
    input wire logic length_in_ready
);
    import tle_pkg::*;
    initial begin
        {link_locked_in, link_up_in, code_error_in, disparity_error_in} = 4'h0;
        {upcoming_level_valid, present_level_valid, data_in_valid, length_in_valid} = 4'h0;
        {upcoming_block_level, present_block_level} = 16'h5A5A;
        {data_in_word, data_in_end, data_in_sync} = 34'h2_5A5A_5A5A;
        length_in_word = 32'hA5A5_5A5A;
    end
    task automatic set_link(input logic lk, input logic up);
        @(posedge pclk);
        link_locked_in <= lk;
        link_up_in <= up;
    endtask : set_link
    // one-cycle error pulses, gap of one cycle between them
    task automatic errs(input logic c, input logic d, input int n);
        repeat (n) begin
            @(posedge pclk);
            code_error_in <= c;
            disparity_error_in <= d;
            @(posedge pclk);
            code_error_in <= 1'b0;
            disparity_error_in <= 1'b0;
        end
    endtask : errs
    task automatic send_levels(input tle_level_t nx, input tle_level_t cu);
        @(posedge pclk);
        {upcoming_level_valid, present_level_valid} <= 2'h3;
        upcoming_block_level <= nx;
        present_block_level <= cu;
        @(posedge pclk);
        {upcoming_level_valid, present_level_valid} <= 2'h0;
        upcoming_block_level <= ~nx;
        present_block_level <= ~cu;
    endtask : send_levels
    // ----------------------------------------
    // pushes: held until ready seen at an edge
    // ----------------------------------------
    task automatic push_data(input tle_word_t w, input logic e, input logic s);
        @(posedge pclk);
        data_in_valid <= 1'b1;
        {data_in_word, data_in_end, data_in_sync} <= {w, e, s};
        do @(posedge pclk); while (data_in_ready !== 1'b1);
        data_in_valid <= 1'b0;
        {data_in_word, data_in_end, data_in_sync} <= ~{w, e, s};
    endtask : push_data
    task automatic push_len(input tle_word_t w);
        @(posedge pclk);
        length_in_valid <= 1'b1;
        length_in_word <= w;
        do @(posedge pclk); while (length_in_ready !== 1'b1);
        length_in_valid <= 1'b0;
        length_in_word <= ~w;
    endtask : push_len
endmodule : tle_tip_model
`default_nettype wire

// *** tb/testbench.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "tle_params.svh"
module testbench;
    import tle_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    tle_addr_t paddr = 8'h00;
    tle_word_t pwdata = 32'h0;
    tle_word_t prdata;
    logic pready, pslverr, lk, up, ce, de, uv, pv, dv, de_end, ds, drdy, lv, lrdy;
    logic grst, erst, irst, rxrst, cfrst, ebrst;
    tle_level_t ul, pl;
    tle_word_t dw, lw, d;
    int n_fail = 0;
    int num_checks = 0;
    logic e;
    always #12.5 pclk = ~pclk;
    tle_link_eb_status i_tle_link_eb_status (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .link_locked_in(lk), .link_up_in(up),
        .code_error_in(ce), .disparity_error_in(de), .upcoming_level_valid(uv),
        .upcoming_block_level(ul), .present_level_valid(pv), .present_block_level(pl),
        .data_in_valid(dv), .data_in_word(dw), .data_in_end(de_end), .data_in_sync(ds),
        .data_in_ready(drdy), .length_in_valid(lv), .length_in_word(lw),
        .length_in_ready(lrdy), .global_refclk_reset(grst), .ethernet_refclk_reset(erst),
        .input_delay_ref_reset(irst), .link_rx_reset(rxrst), .command_fifo_reset(cfrst),
        .event_buffer_reset(ebrst));
    tle_tip_model i_tle_tip_model (.pclk(pclk), .link_locked_in(lk), .link_up_in(up),
        .code_error_in(ce), .disparity_error_in(de), .upcoming_level_valid(uv),
        .upcoming_block_level(ul), .present_level_valid(pv), .present_block_level(pl),
        .data_in_valid(dv), .data_in_word(dw), .data_in_end(de_end), .data_in_sync(ds),
        .data_in_ready(drdy), .length_in_valid(lv), .length_in_word(lw),
        .length_in_ready(lrdy));
    // ----------------------------------------
    // checks and bus tasks
    // ----------------------------------------
    task automatic chk(input string nm, input tle_word_t exp, input tle_word_t got);
        num_checks++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
            n_fail++;
        end
    endtask : chk
    task automatic give_verdict();
        if (n_fail == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict
    task automatic apb(input logic wr, input tle_addr_t a, input tle_word_t wd,
                       output tle_word_t rd, output logic err);
        int n = 0;
        @(posedge pclk);
        {psel, penable, pwrite} <= {1'b1, 1'b0, wr};
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        {psel, penable} <= 2'h0;
    endtask : apb
    task automatic rd(input tle_addr_t a, input tle_word_t exp, input string nm);
        apb(1'b0, a, 32'h0, d, e);
        chk(nm, exp, d);
        chk("slverr", 32'h0, {31'h0, e});
    endtask : rd
    task automatic wr(input tle_addr_t a, input tle_word_t wd);
        apb(1'b1, a, wd, d, e);
        chk("slverr", 32'h0, {31'h0, e});
    endtask : wr
    task automatic ochk(input string nm, input logic exp, ref logic sig);
        @(negedge pclk);
        chk(nm, {31'h0, exp}, {31'h0, sig});
    endtask : ochk
    function automatic tle_word_t eb(logic s, int dc, logic en, int lc);
        return {s, 13'(dc), 1'b0, en, 10'(lc), 2'b0, lc == 0, 2'b0, dc == 0};
    endfunction : eb
    // ----------------------------------------
    // tests
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        ochk("grst", 1'b1, grst);
        ochk("irst", 1'b1, irst);
        ochk("erst", 1'b1, erst);
        ochk("rxrst", 1'b1, rxrst);
        ochk("cmd_rst", 1'b1, cfrst);
        ochk("eb_rst", 1'b0, ebrst);
        rd(`TLE_OFS_CLK_CTRL, 32'h7, "clk_ctrl");
        rd(`TLE_OFS_EB_STATE, eb(0, 0, 0, 0), "eb_idle");
        rd(`TLE_OFS_BLK_LEVEL, 32'h0, "levels");
        wr(`TLE_OFS_CLK_CTRL, 32'h0);
        ochk("grst", 1'b0, grst);
        ochk("irst", 1'b0, irst);
        ochk("erst", 1'b0, erst);
        wr(`TLE_OFS_CLK_CTRL, 32'h4);
        ochk("irst", 1'b1, irst);
        rd(`TLE_OFS_CLK_CTRL, 32'h4, "clk_ctrl");
        apb(1'b0, 8'h04, 32'h0, d, e);
        chk("unmapped", 32'h1, {31'h0, e});
        apb(1'b0, 8'h09, 32'h0, d, e);
        chk("misaligned", 32'h1, {31'h0, e});
        i_tle_tip_model.set_link(1'b1, 1'b0);
        i_tle_tip_model.errs(1'b1, 1'b1, 2);
        rd(`TLE_OFS_LINK_HEALTH, 32'h20000, "health");
        wr(`TLE_OFS_LINK_CTRL, 32'h2);
        ochk("rxrst", 1'b0, rxrst);
        ochk("cmd_rst", 1'b1, cfrst);
        i_tle_tip_model.set_link(1'b1, 1'b1);
        rd(`TLE_OFS_LINK_HEALTH, 32'h30000, "health");
        wr(`TLE_OFS_LINK_CTRL, 32'h0);
        ochk("cmd_rst", 1'b0, cfrst);
        wr(`TLE_OFS_LINK_HEALTH, 32'hFFFF_FFFF);
        i_tle_tip_model.errs(1'b1, 1'b0, 3);
        i_tle_tip_model.errs(1'b1, 1'b1, 1);
        rd(`TLE_OFS_LINK_HEALTH, 32'h30005, "health");
        i_tle_tip_model.errs(1'b1, 1'b1, 32768);
        rd(`TLE_OFS_LINK_HEALTH, 32'h3FFFF, "health");
        wr(`TLE_OFS_LINK_CTRL, 32'h1);
        wr(`TLE_OFS_LINK_CTRL, 32'h0);
        rd(`TLE_OFS_LINK_HEALTH, 32'h30000, "health");
        i_tle_tip_model.send_levels(8'hA5, 8'h3C);
        rd(`TLE_OFS_BLK_LEVEL, 32'hA53C, "levels");
        for (int i = 0; i < 3; i++) i_tle_tip_model.push_data(32'hC0DE_0000 + i, i == 2, 1'b1);
        i_tle_tip_model.push_len(32'h3);
        rd(`TLE_OFS_EB_STATE, eb(1, 3, 0, 1), "eb_blk");
        rd(`TLE_OFS_LEN_POP, 32'h3, "len_pop");
        for (int i = 0; i < 3; i++) begin
            rd(`TLE_OFS_EB_STATE, eb(1, 3 - i, i == 2, 0), "eb_pop");
            rd(`TLE_OFS_DATA_POP, 32'hC0DE_0000 + i, "data_pop");
        end
        rd(`TLE_OFS_EB_STATE, eb(0, 0, 0, 0), "eb_empty");
        rd(`TLE_OFS_DATA_POP, 32'h0, "empty_pop");
        for (int i = 0; i < `TLE_DATA_DEPTH; i++) i_tle_tip_model.push_data(i, 1'b0, 1'b0);
        for (int i = 0; i < `TLE_LEN_DEPTH; i++) i_tle_tip_model.push_len(i);
        rd(`TLE_OFS_EB_STATE, eb(0, 16, 0, 4), "eb_full");
        ochk("data_rdy", 1'b0, drdy);
        ochk("len_rdy", 1'b0, lrdy);
        wr(`TLE_OFS_LINK_CTRL, 32'h4);
        ochk("eb_rst", 1'b1, ebrst);
        wr(`TLE_OFS_LINK_CTRL, 32'h0);
        rd(`TLE_OFS_EB_STATE, eb(0, 0, 0, 0), "eb_flush");
        give_verdict();
    end
    initial begin
        repeat (90000) @(posedge pclk);
        n_fail++;
        give_verdict();
    end
endmodule : testbench
`default_nettype wire
